// [src/lcd_loop_status.v]
// loop-code detection, fifo limit flag and status registers on wishbone
`timescale 1ns/1ps
`include "lcd_defs.vh"
module lcd_loop_status #(
    parameter PTR_W = 5,
    parameter HOLD_CYC = `LCD_HOLD_SEC * `LCD_CLK_HZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    output reg [7:0] wb_dat_o,
    input wire wb_we_i,
    input wire [0:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire rx_bit_en_i,
    input wire rx_data_i,
    input wire [PTR_W-1:0] ja_rd_ptr_i,
    input wire [PTR_W-1:0] ja_wr_ptr_i,
    output reg remote_loopback_o,
    output wire irq_o
);
    reg [3:0] ctrl_q;
    reg [7:0] istat_q;
    reg [7:0] ienable_q;
    reg fifo_limit_flag_q;
    reg loop_code_detect_flag_q;
    reg [1:0] mode_q;
    reg auto_dn_q;
    reg [7:0] istat_d;
    reg loop_code_detect_flag_d;
    reg loopback_d;
    reg [PTR_W-1:0] ptr_diff;
    reg [PTR_W-1:0] ptr_back;
    wire [1:0] mode;
    wire single_rail;
    wire acc;
    wire wr_acc;
    wire rd_istat;
    wire fls_now;
    wire up_en;
    wire dn_en;
    wire up_pres;
    wire up_held;
    wire dn_pres;
    wire dn_held;
    wire [7:0] flags;
    wire [7:0] flags_prev;
    wire [7:0] chg;

    assign mode = {ctrl_q[`LCD_CTRL_MHI], ctrl_q[`LCD_CTRL_MLO]};
    assign single_rail = ctrl_q[`LCD_CTRL_SRLIU] && ctrl_q[`LCD_CTRL_SRFRM];
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_acc = acc && wb_we_i && wb_sel_i[0];
    assign rd_istat = acc && !wb_we_i && (wb_adr_i == `LCD_ADR_ISTAT) && single_rail;

    // distance either way round the ring: pointers wrap, so both modular differences count
    always @* begin
        ptr_diff = ja_wr_ptr_i - ja_rd_ptr_i;
        ptr_back = ja_rd_ptr_i - ja_wr_ptr_i;
    end
    assign fls_now = (ptr_diff <= `LCD_FIFO_NEAR) || (ptr_back <= `LCD_FIFO_NEAR);

    // manual loop-up mode and the auto loop-up search share the loop-up checker
    assign up_en = (mode == `LCD_MODE_UP) ||
        ((mode == `LCD_MODE_AUTO) && (mode_q == `LCD_MODE_AUTO) && !auto_dn_q);
    assign dn_en = (mode == `LCD_MODE_DN) ||
        ((mode == `LCD_MODE_AUTO) && (mode_q == `LCD_MODE_AUTO) && auto_dn_q);

    lcd_pattern_timer #(
        .LEN(`LCD_UP_LEN),
        .CODE(`LCD_UP_CODE),
        .HOLD_CYC(HOLD_CYC)
    ) u_up (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(up_en),
        .bit_en_i(rx_bit_en_i),
        .bit_i(rx_data_i),
        .present_o(up_pres),
        .held_o(up_held)
    );

    lcd_pattern_timer #(
        .LEN(`LCD_DN_LEN),
        .CODE(`LCD_DN_CODE),
        .HOLD_CYC(HOLD_CYC)
    ) u_dn (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(dn_en),
        .bit_en_i(rx_bit_en_i),
        .bit_i(rx_data_i),
        .present_o(dn_pres),
        .held_o(dn_held)
    );

    always @* begin
        loop_code_detect_flag_d = 1'b0;
        loopback_d = remote_loopback_o;
        case (mode)
            `LCD_MODE_OFF: begin
                loop_code_detect_flag_d = 1'b0;
                loopback_d = 1'b0;
            end
            `LCD_MODE_UP: begin
                loop_code_detect_flag_d = up_held && up_pres;
                loopback_d = 1'b0;
            end
            `LCD_MODE_DN: begin
                loop_code_detect_flag_d = dn_held && dn_pres;
                loopback_d = 1'b0;
            end
            `LCD_MODE_AUTO: begin
                if (mode_q != `LCD_MODE_AUTO) begin
                    loop_code_detect_flag_d = 1'b0;
                    loopback_d = 1'b0;
                end else if (!auto_dn_q) begin
                    loop_code_detect_flag_d = up_held;
                    loopback_d = up_held;
                end else if (dn_held) begin
                    loop_code_detect_flag_d = 1'b0;
                    loopback_d = 1'b0;
                end else begin
                    loop_code_detect_flag_d = 1'b1;
                    loopback_d = 1'b1;
                end
            end
            default: begin
                loop_code_detect_flag_d = 1'b0;
                loopback_d = 1'b0;
            end
        endcase
    end

    assign flags = {2'b00, fifo_limit_flag_q, 1'b0, loop_code_detect_flag_q, 3'b000};
    assign flags_prev = {2'b00, fls_now, 1'b0, loop_code_detect_flag_d, 3'b000};
    assign chg = flags ^ flags_prev;

    // a change in the read cycle still lands: set wins over clear
    always @* begin
        istat_d = istat_q;
        if (rd_istat) begin
            istat_d = 8'h00;
        end
        if (wr_acc && (wb_adr_i == `LCD_ADR_ICLR)) begin
            istat_d = istat_d & ~wb_dat_i;
        end
        if (single_rail) begin
            istat_d = istat_d | chg;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 4'h0;
            istat_q <= 8'h00;
            ienable_q <= 8'h00;
            fifo_limit_flag_q <= 1'b0;
            loop_code_detect_flag_q <= 1'b0;
            mode_q <= `LCD_MODE_OFF;
            auto_dn_q <= 1'b0;
            remote_loopback_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            mode_q <= mode;
            fifo_limit_flag_q <= fls_now;
            loop_code_detect_flag_q <= loop_code_detect_flag_d;
            remote_loopback_o <= loopback_d;
            auto_dn_q <= (mode == `LCD_MODE_AUTO) && (mode_q == `LCD_MODE_AUTO) && loopback_d;
            istat_q <= istat_d;
            wb_ack_o <= acc;
            if (wr_acc) begin
                case (wb_adr_i)
                    `LCD_ADR_IENA: ienable_q <= wb_dat_i & 8'h28;
                    `LCD_ADR_CTRL: ctrl_q <= wb_dat_i[3:0];
                    default: ctrl_q <= ctrl_q;
                endcase
            end
            if (acc && !wb_we_i) begin
                case (wb_adr_i)
                    `LCD_ADR_STATUS: wb_dat_o <= single_rail ? flags : 8'h00;
                    `LCD_ADR_ISTAT: wb_dat_o <= single_rail ? istat_q : 8'h00;
                    `LCD_ADR_IENA: wb_dat_o <= ienable_q;
                    `LCD_ADR_CTRL: wb_dat_o <= {4'h0, ctrl_q};
                    default: wb_dat_o <= 8'h00;
                endcase
            end
        end
    end

    // level interrupt while an enabled latched bit stands
    assign irq_o = |(istat_q & ienable_q);
endmodule

// [src/lcd_defs.vh]
// constants for the loop-code detect and fifo limit status block
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH
`define LCD_ADR_STATUS 4'h0
`define LCD_ADR_ISTAT 4'h1
`define LCD_ADR_IENA 4'h2
`define LCD_ADR_ICLR 4'h3
`define LCD_ADR_CTRL 4'h4
`define LCD_BIT_FLS 5
`define LCD_BIT_LOOP_CODE_DETECT 3
`define LCD_CTRL_MLO 0
`define LCD_CTRL_MHI 1
`define LCD_CTRL_SRLIU 2
`define LCD_CTRL_SRFRM 3
`define LCD_FIFO_NEAR 3
`define LCD_HOLD_SEC 5
`define LCD_CLK_HZ 100000000
`define LCD_UP_CODE 5'h01
`define LCD_UP_LEN 5
`define LCD_DN_CODE 3'h1
`define LCD_DN_LEN 3
`define LCD_MODE_OFF 2'h0
`define LCD_MODE_UP 2'h1
`define LCD_MODE_DN 2'h2
`define LCD_MODE_AUTO 2'h3
`endif

// [src/lcd_pattern_timer.v]
// repeating pattern checker with persistence timer
`timescale 1ns/1ps
`include "lcd_defs.vh"
module lcd_pattern_timer #(
    parameter LEN = 5,
    parameter [LEN-1:0] CODE = 5'h01,
    parameter HOLD_CYC = 500000000
) (
    input wire clk_i,
    input wire rst_i,
    input wire en_i,
    input wire bit_en_i,
    input wire bit_i,
    output wire present_o,
    output reg held_o
);
    reg [LEN-1:0] hist_q;
    reg [LEN-1:0] hist_d;
    reg [7:0] fill_q;
    reg [31:0] cnt_q;
    wire match;
    // pattern is periodic: any rotation of the code counts as aligned
    function rot_match;
        input [LEN-1:0] h;
        integer r;
        reg [2*LEN-1:0] dbl;
        begin
            rot_match = 1'b0;
            dbl = {CODE, CODE};
            for (r = 0; r < LEN; r = r + 1) begin
                if (dbl[r +: LEN] == h) begin
                    rot_match = 1'b1;
                end
            end
        end
    endfunction
    assign match = rot_match(hist_q);
    assign present_o = en_i && (fill_q >= LEN) && match;
    always @* begin
        hist_d = {hist_q[LEN-2:0], bit_i};
    end
    always @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            hist_q <= {LEN{1'b0}};
            fill_q <= 8'h00;
            cnt_q <= 32'h0;
            held_o <= 1'b0;
        end else begin
            if (bit_en_i) begin
                hist_q <= hist_d;
                if (fill_q < LEN) begin
                    fill_q <= fill_q + 8'h01;
                end
            end
            // persistence must be strictly longer than the hold time
            if (!present_o) begin
                cnt_q <= 32'h0;
                held_o <= 1'b0;
            end else if (cnt_q < HOLD_CYC) begin
                cnt_q <= cnt_q + 32'h1;
            end else begin
                held_o <= 1'b1;
            end
        end
    end
endmodule

// [tb/lcd_loop_status_sva.sv]
// assertions on the ports of the loop status block
`timescale 1ns/1ps
module lcd_loop_status_sva #(parameter HOLD_CYC = 50) (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] wb_adr_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [7:0] wb_dat_o,
    input wire remote_loopback_o,
    input wire irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    localparam [3:0] CTRL_ADR = 4'h4;
    // cycles since the last control write, saturating; a mode entry restarts the search
    reg [31:0] since_ctl_q;
    always @(posedge clk_i) begin
        if (rst_i || (wb_ack_o && wb_we_i && wb_adr_i == CTRL_ADR))
            since_ctl_q <= 32'h0;
        else if (~since_ctl_q != 32'h0)
            since_ctl_q <= since_ctl_q + 32'h1;
    end
    // cycles since loopback last moved, saturating
    reg [31:0] run_q;
    always @(posedge clk_i) begin
        if (rst_i || $changed(remote_loopback_o))
            run_q <= 32'h0;
        else if (~run_q != 32'h0)
            run_q <= run_q + 32'h1;
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_next: assert property (s_req |=> s_ack) else $error("no ack pulse after request");
    a_idle_no_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
    a_dat_on_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data moved outside a read");
    a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !wb_ack_o && !remote_loopback_o && !irq_o && wb_dat_o == 8'h00)
        else $error("outputs not cleared by reset");
    a_irq_fall_bus: assert property ($fell(irq_o) |-> wb_ack_o)
        else $error("interrupt dropped without bus access");
    a_loop_rise_late: assert property ($rose(remote_loopback_o) |->
        run_q > HOLD_CYC && since_ctl_q > HOLD_CYC)
        else $error("loopback set before hold time");
    a_loop_fall_late: assert property ($fell(remote_loopback_o) |-> run_q > HOLD_CYC)
        else $error("loopback released before hold time");
endmodule

// [tb/lcd_line_model.sv]
// far-end line equipment sending loop codes
`timescale 1ns/1ps
module lcd_line_model (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] pat_i,
    output reg bit_en_o,
    output reg data_o
);
    reg [2:0] idx_q;
    // pattern 1 sends 00001, 2 sends 001, else idle ones
    always @(posedge clk_i) begin
        if (rst_i) begin
            bit_en_o <= 1'b0;
            idx_q <= 3'h0;
            data_o <= 1'b1;
        end else if (bit_en_o) begin
            bit_en_o <= 1'b0;
            data_o <= ~data_o; // no bit valid: line toggles so stale values never match
        end else begin
            bit_en_o <= 1'b1;
            idx_q <= (idx_q >= (pat_i == 2'h2 ? 3'h2 : 3'h4)) ? 3'h0 : idx_q + 3'h1;
            data_o <= (pat_i == 2'h1) ? (idx_q == 3'h4) :
                      (pat_i == 2'h2) ? (idx_q == 3'h2) : 1'b1;
        end
    end
endmodule

// [tb/lcd_loop_status_tb_top.sv]
// testbench for loop-code detect and fifo limit status
`timescale 1ns/1ps
module lcd_loop_status_tb_top;
    localparam HOLD = 50;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [3:0] adr = 4'h0;
    reg [7:0] wdat = 8'h00;
    reg we = 1'b0;
    reg cyc = 1'b0;
    reg [1:0] pat = 2'h0;
    reg [4:0] rp = 5'h00;
    reg [4:0] wp = 5'h10;
    wire [7:0] rdat;
    wire ack, ben, bdat, lpb, irq;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer ticks = 0;
    always #5 clk_i = ~clk_i;
    lcd_loop_status #(.PTR_W(5), .HOLD_CYC(HOLD)) i_lcd_loop_status (.clk_i(clk_i),
        .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
        .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .rx_bit_en_i(ben),
        .rx_data_i(bdat), .ja_rd_ptr_i(rp), .ja_wr_ptr_i(wp), .remote_loopback_o(lpb),
        .irq_o(irq));
    lcd_line_model i_lcd_line_model (.clk_i(clk_i), .rst_i(rst_i), .pat_i(pat),
        .bit_en_o(ben), .data_o(bdat));
    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input [3:0] a, input [7:0] d, input w, output [7:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        adr <= a;
        wdat <= d;
        we <= w;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        r = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task wr(input [3:0] a, input [7:0] d);
        reg [7:0] r;
        bus(a, d, 1'b1, r);
    endtask
    task rd(input [3:0] a, input [7:0] e);
        reg [7:0] r;
        bus(a, 8'h00, 1'b0, r);
        chk(r, e);
    endtask
    task w(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task t_reset;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h7, 8'h00);
        wr(4'h4, 8'h0c);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h00);
        wr(4'h2, 8'hff);
        rd(4'h2, 8'h28);
        $display("reset test done");
    endtask
    task t_fifo;
        wr(4'h2, 8'h20);
        wp <= 5'h0d;
        rp <= 5'h0a;
        w(3);
        rd(4'h0, 8'h20);
        chk({7'h0, irq}, 8'h01);
        wr(4'h4, 8'h04);
        rd(4'h0, 8'h00);
        wr(4'h4, 8'h0c);
        rd(4'h1, 8'h20);
        chk({7'h0, irq}, 8'h00);
        wp <= 5'h0e;
        w(3);
        rd(4'h0, 8'h00);
        chk({7'h0, irq}, 8'h01);
        rp <= 5'h11;
        w(3);
        rd(4'h0, 8'h20);
        wp <= 5'h01;
        rp <= 5'h1e;
        w(3);
        rd(4'h0, 8'h20);
        wp <= 5'h10;
        rp <= 5'h00;
        w(3);
        wr(4'h3, 8'h20);
        rd(4'h1, 8'h00);
        $display("fifo test done");
    endtask
    task t_manual(input [1:0] m);
        wr(4'h4, 8'h0c | m);
        wr(4'h2, 8'h08);
        pat <= m;
        w(30);
        rd(4'h0, 8'h00);
        w(100);
        rd(4'h0, 8'h08);
        pat <= 2'h0;
        w(20);
        rd(4'h0, 8'h00);
        chk({7'h0, irq}, 8'h01);
        rd(4'h1, 8'h08);
        chk({7'h0, irq}, 8'h00);
        $display("manual test %0d done", m);
    endtask
    task t_auto;
        wr(4'h4, 8'h0f);
        rd(4'h0, 8'h00);
        pat <= 2'h1;
        w(130);
        rd(4'h0, 8'h08);
        chk({7'h0, lpb}, 8'h01);
        pat <= 2'h0;
        w(100);
        rd(4'h0, 8'h08);
        chk({7'h0, lpb}, 8'h01);
        pat <= 2'h2;
        w(30);
        chk({7'h0, lpb}, 8'h01);
        w(100);
        chk({7'h0, lpb}, 8'h00);
        rd(4'h0, 8'h00);
        chk({7'h0, irq}, 8'h01);
        pat <= 2'h0;
        rd(4'h1, 8'h08);
        $display("auto test done");
    endtask
    task t_off;
        wr(4'h4, 8'h0c);
        pat <= 2'h1;
        w(130);
        rd(4'h0, 8'h00);
        chk({7'h0, lpb}, 8'h00);
        pat <= 2'h0;
        $display("off test done");
    endtask
    // cut a hang short; tests need about 950 cycles
    always @(posedge clk_i) begin
        ticks = ticks + 1;
        if (ticks == 6000) begin
            n_fail = n_fail + 1;
            test_done;
        end
    end
    initial begin
        w(20);
        rst_i <= 1'b0;
        t_reset;
        t_fifo;
        t_manual(2'h1);
        t_manual(2'h2);
        t_auto;
        t_off;
        test_done;
    end
endmodule
bind lcd_loop_status lcd_loop_status_sva #(.HOLD_CYC(HOLD_CYC)) i_lcd_loop_status_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wb_adr_i(wb_adr_i),
    .remote_loopback_o(remote_loopback_o), .irq_o(irq_o));
